// *** hdl/lbc_top.sv ***
/*
 * Local bus cycle control: bus state sequencing, direction, lock,
 * hold handover, wait and recovery insertion, and reset strap capture.
 * Assumes the request port comes from logic on CLOCK, pins and straps
 * arrive asynchronously, and a pad ring resolves levels from the enables.
 */
`include "lbc_defs.svh"
module lbc_top
(
    input  wire logic            CLOCK,
    input  wire logic            SRST,
    input  wire lbc_pkg::lbc_req_s REQ,
    output logic                 REQ_TAKEN,
    output logic                 XFER_DONE,
    input  wire logic            HOLD_REQ,
    input  wire logic            READY_RECOVER_IN_N,
    input  wire logic            MC_READY_N,
    input  wire logic            CORE_HOLD_STRAP,
    input  wire logic            FLOAT_ALL_STRAP_N,
    input  wire logic            SELFTEST_STRAP,
    input  wire logic            CONFIG_RETRY_STRAP,
    input  wire logic            CORE_RESET_CLEAR,
    input  wire logic            CONFIG_RETRY_CLEAR,
    output lbc_pkg::lbc_ctrl_s   CTRL_OUT,
    output logic                 CTRL_OE,
    output logic                 BUS_HOLD_GRANT,
    output logic                 GRANT_OE,
    output logic                 LOCAL_READY_OUT_N,
    output logic                 LOCAL_READY_OE,
    output logic                 CORE_IN_RESET,
    output logic                 PERIPH_CFG_OPEN,
    output logic                 CONFIG_RETRY_ACTIVE,
    output logic                 FLOAT_MODE,
    output logic                 CLOCK_STOP,
    output logic                 SELFTEST_INTERNAL_EN,
    output logic                 BUS_CONFIDENCE_EN
);
    import lbc_pkg::*;

    function automatic logic in_data(input lbc_state_e s);
        in_data = (s == DATA_STATE) || (s == WAIT_STATE);
    endfunction

    // two-flop synchronisers for the hold and ready/recover pins and the straps
    logic                    hold_s1;
    logic                    hold_s2;
    logic                    rdy_s1;
    logic                    rdy_s2;
    logic [`LBC_STRAP_W-1:0] strap_s1;
    logic [`LBC_STRAP_W-1:0] strap_s2;

    always_ff @(posedge CLOCK)
    begin
        hold_s1  <= HOLD_REQ;
        hold_s2  <= hold_s1;
        rdy_s1   <= READY_RECOVER_IN_N;
        rdy_s2   <= rdy_s1;
        strap_s1 <= {CONFIG_RETRY_STRAP, SELFTEST_STRAP,
                     FLOAT_ALL_STRAP_N, CORE_HOLD_STRAP};
        strap_s2 <= strap_s1;
    end

    // strap capture, core reset and configuration retry
    logic [`LBC_STRAP_W-1:0] strap_reg;
    logic [`LBC_STRAP_W-1:0] strap_next;
    logic                    core_rst_reg;
    logic                    core_rst_next;
    logic                    retry_reg;
    logic                    retry_next;
    logic                    float_reg;
    logic                    float_next;
    logic                    selftest_strap_reg;
    logic                    selftest_strap_next;

    always_comb
    begin
        strap_next    = strap_reg;
        core_rst_next = core_rst_reg;
        retry_next    = retry_reg;
        float_next    = float_reg;
        selftest_strap_next    = selftest_strap_reg;
        if (SRST)
        begin
            strap_next    = strap_s2;
            core_rst_next = 1'b1;
            retry_next    = 1'b0;
            float_next    = 1'b0;
            selftest_strap_next    = 1'b0;
        end
        else
        begin
            // core released at CORE_HOLD_STRAP, or held until software clears it
            if (core_rst_reg && (strap_reg[`LBC_STRAP_COREHLD]
                                 || CORE_RESET_CLEAR))
                core_rst_next = 1'b0;
            // held-core mode forces the retry strap inactive
            if (!float_reg && !selftest_strap_reg && core_rst_reg)
                retry_next = strap_reg[`LBC_STRAP_RETRY]
                             && strap_reg[`LBC_STRAP_COREHLD];
            if (CONFIG_RETRY_CLEAR)
                retry_next = 1'b0;
            float_next = float_reg
                         || !strap_reg[`LBC_STRAP_FLOAT];
            selftest_strap_next = 1'b1;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        strap_reg    <= strap_next;
        core_rst_reg <= core_rst_next;
        retry_reg    <= retry_next;
        float_reg    <= float_next;
        selftest_strap_reg    <= selftest_strap_next;
    end

    assign CORE_IN_RESET        = core_rst_reg;
    assign CONFIG_RETRY_ACTIVE  = retry_reg;
    assign PERIPH_CFG_OPEN      = !retry_reg;
    assign FLOAT_MODE           = float_reg;
    assign CLOCK_STOP           = float_reg;
    assign SELFTEST_INTERNAL_EN = selftest_strap_reg && !float_reg
                                  && strap_reg[`LBC_STRAP_SELFTEST_STRAP];
    assign BUS_CONFIDENCE_EN    = selftest_strap_reg && !float_reg;

    // bus state machine and pin registers
    lbc_state_e              state_reg;
    lbc_state_e              state_next;
    logic [`LBC_BEAT_W-1:0]  beat_reg;
    logic [`LBC_BEAT_W-1:0]  beat_next;
    logic                    last_lock_reg;
    logic                    last_lock_next;
    lbc_ctrl_s               ctrl_reg;
    lbc_ctrl_s               ctrl_next;
    logic                    grant_reg;
    logic                    grant_next;
    logic                    lrdy_reg;
    logic                    lrdy_next;
    logic                    take;
    logic                    beat_ok;
    logic                    may_grant;

    assign beat_ok   = in_data(state_reg)
                       && (rdy_s2 == `LBC_RDY_SAMPLE);
    assign may_grant = hold_s2 && !float_reg
                       && (ctrl_reg.bus_lock_n == `LBC_NEG_IDLE);
    assign take      = (state_reg == IDLE_STATE) && REQ.valid
                       && !may_grant && !float_reg;

    always_comb
    begin
        state_next     = state_reg;
        beat_next      = beat_reg;
        last_lock_next = last_lock_reg;
        ctrl_next      = ctrl_reg;
        grant_next     = grant_reg;
        lrdy_next      = MC_READY_N;
        case (state_reg)
            IDLE_STATE:
            begin
                if (may_grant)
                begin
                    state_next = HOLD_STATE;
                    grant_next = 1'b1;
                end
                else if (take)
                begin
                    state_next               = ADDRESS_STATE;
                    beat_next                = REQ.beats;
                    last_lock_next           = REQ.lock_last;
                    ctrl_next.write_not_read = REQ.write;
                    ctrl_next.access_type    = REQ.data_access;
                    ctrl_next.transfer_direction = REQ.write ?
                        `LBC_DIR_TRANSMIT : `LBC_DIR_RECEIVE;
                    if (REQ.lock)
                        ctrl_next.bus_lock_n = `LBC_NEG_ACTIVE;
                end
            end
            ADDRESS_STATE:
            begin
                state_next = DATA_STATE;
                ctrl_next.data_phase_enable_n = `LBC_NEG_ACTIVE;
            end
            DATA_STATE, WAIT_STATE:
            begin
                if (!beat_ok)
                    state_next = WAIT_STATE;
                else if (beat_reg != '0)
                begin
                    state_next = DATA_STATE;
                    beat_next  = beat_reg - `LBC_BEAT_W'(1);
                end
                else
                begin
                    state_next = RECOVERY_STATE;
                    ctrl_next.data_phase_enable_n = `LBC_NEG_IDLE;
                    if (last_lock_reg)
                        ctrl_next.bus_lock_n = `LBC_NEG_IDLE;
                end
            end
            RECOVERY_STATE:
            begin
                if (rdy_s2 == `LBC_RCV_DONE)
                    state_next = IDLE_STATE;
            end
            HOLD_STATE:
            begin
                if (!hold_s2)
                begin
                    state_next = IDLE_STATE;
                    grant_next = 1'b0;
                end
            end
            default:
            begin
                state_next = IDLE_STATE;
            end
        endcase
        if (SRST)
        begin
            state_next     = IDLE_STATE;
            beat_next      = '0;
            last_lock_next = 1'b0;
            grant_next     = 1'b0;
            lrdy_next      = `LBC_NEG_IDLE;
            ctrl_next.write_not_read      = `LBC_WNR_READ;
            ctrl_next.access_type         = `LBC_ACC_CODE;
            ctrl_next.transfer_direction  = `LBC_DIR_RECEIVE;
            ctrl_next.data_phase_enable_n = `LBC_NEG_IDLE;
            ctrl_next.bus_lock_n          = `LBC_NEG_IDLE;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        state_reg     <= state_next;
        beat_reg      <= beat_next;
        last_lock_reg <= last_lock_next;
        ctrl_reg      <= ctrl_next;
        grant_reg     <= grant_next;
        lrdy_reg      <= lrdy_next;
    end

    assign REQ_TAKEN         = take;
    assign XFER_DONE         = beat_ok;
    assign CTRL_OUT          = ctrl_reg;
    // control lines float in hold and in float mode; grant and local ready lines float in float mode only
    assign CTRL_OE           = !grant_reg && !float_reg;
    assign BUS_HOLD_GRANT    = grant_reg;
    assign GRANT_OE          = !float_reg;
    assign LOCAL_READY_OUT_N = lrdy_reg;
    assign LOCAL_READY_OE    = !float_reg;

    // checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);

    sequence s_hold_asked;
        (state_reg == IDLE_STATE) && may_grant;
    endsequence

    sequence s_hold_given;
        grant_reg && !CTRL_OE && (state_reg == HOLD_STATE);
    endsequence

    sequence s_access_begin;
        (state_reg == ADDRESS_STATE);
    endsequence

    a_hold_entry: assert property (
        s_hold_asked |=> s_hold_given)
        else $error("hold request not granted at boundary");

    a_hold_exit: assert property (
        (state_reg == HOLD_STATE) && !hold_s2
        |=> !grant_reg && CTRL_OE && (state_reg == IDLE_STATE))
        else $error("hold release did not restore the bus");

    a_grant_lock: assert property (
        $rose(grant_reg) |-> $past(ctrl_reg.bus_lock_n) == `LBC_NEG_IDLE)
        else $error("grant issued while lock asserted");

    a_grant_boundary: assert property (
        $rose(grant_reg) |-> $past(state_reg) == IDLE_STATE)
        else $error("grant issued mid access");

    a_dir_den_stable: assert property (
        (ctrl_reg.data_phase_enable_n == `LBC_NEG_ACTIVE)
        && ($past(ctrl_reg.data_phase_enable_n) == `LBC_NEG_ACTIVE)
        |-> $stable(ctrl_reg.transfer_direction))
        else $error("direction changed while data enabled");

    a_den_first: assert property (
        s_access_begin ##1 (state_reg == DATA_STATE)
        |-> ctrl_reg.data_phase_enable_n == `LBC_NEG_ACTIVE)
        else $error("data enable missing in first data cycle");

    a_type_held: assert property (
        take ##1 s_access_begin
        |-> ctrl_reg.access_type == $past(REQ.data_access)
            && ctrl_reg.write_not_read == $past(REQ.write))
        else $error("access type or write flag wrong");

    a_attr_stable: assert property (
        in_data(state_reg)
        |-> $stable(ctrl_reg.access_type) && $stable(ctrl_reg.write_not_read)
            && ctrl_reg.transfer_direction == ctrl_reg.write_not_read)
        else $error("attributes moved during data states");

    a_wait_insert: assert property (
        in_data(state_reg) && (rdy_s2 != `LBC_RDY_SAMPLE)
        |=> (state_reg == WAIT_STATE))
        else $error("wait state not inserted");

    a_recover_ext: assert property (
        (state_reg == RECOVERY_STATE) && (rdy_s2 != `LBC_RCV_DONE)
        |=> (state_reg == RECOVERY_STATE) [*1] ##0 CTRL_OUT == $past(CTRL_OUT))
        else $error("recovery ended early");

    a_lock_release: assert property (
        in_data(state_reg) && beat_ok && (beat_reg == '0) && last_lock_reg
        |=> ctrl_reg.bus_lock_n == `LBC_NEG_IDLE)
        else $error("lock not released on last transfer");

    a_lock_first: assert property (
        take && REQ.lock |=> ctrl_reg.bus_lock_n == `LBC_NEG_ACTIVE)
        else $error("lock not asserted in first clock");

    a_den_last: assert property (
        in_data(state_reg) && beat_ok && (beat_reg == '0)
        |=> ctrl_reg.data_phase_enable_n == `LBC_NEG_IDLE)
        else $error("data enable held past last transfer");

    a_core_held: assert property (
        core_rst_reg && !strap_reg[`LBC_STRAP_COREHLD] && !CORE_RESET_CLEAR
        |=> core_rst_reg)
        else $error("core left reset without clear");

    a_float_hiz: assert property (
        float_reg |-> !CTRL_OE && !GRANT_OE && !LOCAL_READY_OE && CLOCK_STOP)
        else $error("outputs driven in float mode");

    a_lrdy_copy: assert property (
        !$past(SRST) |-> LOCAL_READY_OUT_N == $past(MC_READY_N))
        else $error("local ready does not copy controller ready");
endmodule

// *** hdl/lbc_defs.svh ***
/*
 * Constants of the local bus cycle control block: pin encodings,
 * reset values and field widths.
 * Assumes it is included by its bare name before the package and the top.
 */
`ifndef LBC_DEFS_SVH
`define LBC_DEFS_SVH
`define LBC_BEAT_W        2
`define LBC_ACC_CODE      1'b0
`define LBC_ACC_DATA      1'b1
`define LBC_DIR_RECEIVE   1'b0
`define LBC_DIR_TRANSMIT  1'b1
`define LBC_WNR_READ      1'b0
`define LBC_WNR_WRITE     1'b1
`define LBC_RDY_SAMPLE    1'b0
`define LBC_RCV_DONE      1'b1
`define LBC_NEG_IDLE      1'b1
`define LBC_NEG_ACTIVE    1'b0
`define LBC_STRAP_W       4
`define LBC_STRAP_COREHLD 0
`define LBC_STRAP_FLOAT   1
`define LBC_STRAP_SELFTEST_STRAP   2
`define LBC_STRAP_RETRY   3
`define LBC_STRAP_RST     4'hf
`endif

// *** hdl/lbc_pkg.sv ***
/*
 * Types of the local bus cycle control block.
 * Assumes lbc_defs.svh is reachable on the include path.
 */
`include "lbc_defs.svh"
package lbc_pkg;
    typedef enum logic [2:0] {
        IDLE_STATE,
        ADDRESS_STATE,
        DATA_STATE,
        WAIT_STATE,
        RECOVERY_STATE,
        HOLD_STATE
    } lbc_state_e;

    typedef struct packed {
        logic                    valid;
        logic                    write;
        logic                    data_access;
        logic                    lock;
        logic                    lock_last;
        logic [`LBC_BEAT_W-1:0]  beats;
    } lbc_req_s;

    typedef struct packed {
        logic write_not_read;
        logic access_type;
        logic transfer_direction;
        logic data_phase_enable_n;
        logic bus_lock_n;
    } lbc_ctrl_s;
endpackage

// *** tb/lbc_ext_agent.sv ***
/*
 * Far-side model: an external memory controller answering ready/recover
 * and an external master asking for the bus.
 * Assumes it shares the block clock and sees the block pins directly.
 */
module lbc_ext_agent
(
    input  wire logic       clk,
    input  wire logic       den_n,
    input  wire logic [3:0] wait_cycles,
    input  wire logic [3:0] rcv_cycles,
    input  wire logic       want_bus,
    input  wire logic       grant,
    output logic            ready_n,
    output logic            hold_req,
    output logic            drives_lines
);
    logic [3:0] cnt;
    logic [3:0] since;
    logic       den_q;

    initial
    begin
        cnt = 4'h0;
        den_q = 1'b1;
        hold_req = 1'b0;
        drives_lines = 1'b0;
    end

    always @(posedge clk)
    begin
        den_q <= den_n;
        if (den_n !== den_q)
            cnt <= 4'h1;
        else if (cnt != 4'hf)
            cnt <= cnt + 4'h1;
        // stop driving the lines before the request is dropped
        if (want_bus)
            hold_req <= 1'b1;
        else if (!drives_lines)
            hold_req <= 1'b0;
        drives_lines <= want_bus && grant && hold_req;
    end

    // data cycles: ready after the wait count; otherwise low for the
    // recovery count, then the pull-up level
    // den_n moves on the edge this model samples it, so a change is seen
    // one cycle late; count cycles from the change itself
    assign since = (den_n !== den_q) ? 4'h0 : cnt;

    always_comb
        if (den_n === 1'b0)
            ready_n = (since < wait_cycles);
        else
            ready_n = (since >= rcv_cycles);
endmodule

// *** tb/lbc_top_tb.sv ***
/*
 * Self-checking bench of the local bus cycle control block.
 * Assumes the design files and the far-side model lbc_ext_agent.
 */
module lbc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lbc_pkg::*;

    logic       clk, srst, req_taken, xfer_done, hold_req, rdy_n;
    logic       mc_rdy_n, ch, fl_n, st, rt, core_clr, retry_clr;
    logic       ctrl_oe, grant, grant_oe, lro_n, lro_oe, core_rst;
    logic       periph_open, retry_act, float_mode, clock_stop;
    logic       st_int, bus_conf, want_bus, drives_lines;
    logic [3:0] wait_cycles, rcv_cycles;
    lbc_req_s   req;
    lbc_ctrl_s  ctrl;
    int         fail_count;
    int         samples_checked;

    lbc_top lbc_top_inst (.CLOCK(clk), .SRST(srst), .REQ(req),
        .REQ_TAKEN(req_taken), .XFER_DONE(xfer_done),
        .HOLD_REQ(hold_req), .READY_RECOVER_IN_N(rdy_n),
        .MC_READY_N(mc_rdy_n), .CORE_HOLD_STRAP(ch),
        .FLOAT_ALL_STRAP_N(fl_n), .SELFTEST_STRAP(st),
        .CONFIG_RETRY_STRAP(rt), .CORE_RESET_CLEAR(core_clr),
        .CONFIG_RETRY_CLEAR(retry_clr), .CTRL_OUT(ctrl),
        .CTRL_OE(ctrl_oe), .BUS_HOLD_GRANT(grant), .GRANT_OE(grant_oe),
        .LOCAL_READY_OUT_N(lro_n), .LOCAL_READY_OE(lro_oe),
        .CORE_IN_RESET(core_rst), .PERIPH_CFG_OPEN(periph_open),
        .CONFIG_RETRY_ACTIVE(retry_act), .FLOAT_MODE(float_mode),
        .CLOCK_STOP(clock_stop), .SELFTEST_INTERNAL_EN(st_int),
        .BUS_CONFIDENCE_EN(bus_conf));

    lbc_ext_agent lbc_ext_agent_inst (.clk(clk),
        .den_n(ctrl.data_phase_enable_n), .wait_cycles(wait_cycles),
        .rcv_cycles(rcv_cycles), .want_bus(want_bus), .grant(grant),
        .ready_n(rdy_n), .hold_req(hold_req),
        .drives_lines(drives_lines));

    initial
    begin
        clk = 1'b0;
        forever
            #5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic timeout(input string what);
        fail_count++;
        $display("[ERR] %s expected done seen timeout", what);
        report_and_stop();
    endtask

    task automatic do_reset(input logic c, f, s, r);
        @(posedge clk);
        srst <= 1'b1;
        {ch, fl_n, st, rt} <= {c, f, s, r};
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic wait_grant(input logic v);
        int n;
        n = 0;
        while (grant !== v)
        begin
            if (++n > 40)
                timeout("grant");
            @(negedge clk);
        end
    endtask

    task automatic run_access(input logic w, d, lk, last,
                              input logic [1:0] b, input int gap);
        int  n;
        int  done;
        done = 0;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, w, d, lk, last, b};
        @(negedge clk);
        while (req_taken !== 1'b1)
        begin
            if (++n > 40)
                timeout("take");
            @(negedge clk);
        end
        chk("recovery gap", 8'h1, 8'(n >= gap));
        @(posedge clk);
        req.valid <= 1'b0;
        @(negedge clk);
        chk("addr wnr", 8'(w), 8'(ctrl.write_not_read));
        chk("addr type", 8'(d), 8'(ctrl.access_type));
        chk("addr dir", 8'(w), 8'(ctrl.transfer_direction));
        chk("addr lock", 8'(!(lk | last)), 8'(ctrl.bus_lock_n));
        n = 0;
        while (done < b + 1 || ctrl.data_phase_enable_n !== 1'b1)
        begin
            @(negedge clk);
            if (xfer_done === 1'b1)
                done++;
            if (ctrl.data_phase_enable_n === 1'b0)
            begin
                chk("data wnr", 8'(w), 8'(ctrl.write_not_read));
                chk("data type", 8'(d), 8'(ctrl.access_type));
                chk("data dir", 8'(w), 8'(ctrl.transfer_direction));
                chk("data lock", 8'(!(lk | last)),
                    8'(ctrl.bus_lock_n));
                chk("grant in access", 8'h0, 8'(grant));
            end
            if (++n > 60)
                timeout("transfer");
        end
        chk("transfers", 8'(b) + 8'h1, 8'(done));
    endtask

    task automatic t_straps_run;
        do_reset(1'b1, 1'b1, 1'b1, 1'b1);
        chk("core reset", 8'h0, 8'(core_rst));
        chk("retry", 8'h1, 8'(retry_act));
        chk("periph open", 8'h0, 8'(periph_open));
        chk("self test", 8'h1, 8'(st_int));
        chk("bus test", 8'h1, 8'(bus_conf));
        @(posedge clk);
        retry_clr <= 1'b1;
        @(posedge clk);
        retry_clr <= 1'b0;
        @(negedge clk);
        chk("periph open", 8'h1, 8'(periph_open));
    endtask

    task automatic t_straps_held;
        do_reset(1'b0, 1'b1, 1'b0, 1'b1);
        chk("core held", 8'h1, 8'(core_rst));
        chk("periph open", 8'h1, 8'(periph_open));
        chk("self test", 8'h0, 8'(st_int));
        chk("bus test", 8'h1, 8'(bus_conf));
        @(posedge clk);
        core_clr <= 1'b1;
        @(posedge clk);
        core_clr <= 1'b0;
        @(negedge clk);
        chk("core held", 8'h0, 8'(core_rst));
    endtask

    task automatic t_access_kinds;
        for (int i = 0; i < 4; i++)
        begin
            wait_cycles <= 4'(i);
            rcv_cycles <= 4'(3 - i);
            run_access(i[0], i[1], 1'b0, 1'b0, 2'(i),
                       i > 0 ? 4 - i : 0);
        end
    endtask

    task automatic t_lock_hold;
        run_access(1'b0, 1'b1, 1'b1, 1'b0, 2'h0, 0);
        want_bus <= 1'b1;
        run_access(1'b1, 1'b1, 1'b0, 1'b1, 2'h1, 0);
        wait_grant(1'b1);
        chk("ctrl oe", 8'h0, 8'(ctrl_oe));
        @(posedge clk);
        req <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0};
        repeat (3)
        begin
            @(negedge clk);
            chk("taken in hold", 8'h0, 8'(req_taken));
            chk("bus contention", 8'h0, 8'(drives_lines & ctrl_oe));
        end
        @(posedge clk);
        req.valid <= 1'b0;
        want_bus <= 1'b0;
        @(negedge clk);
        wait_grant(1'b0);
        chk("ctrl oe", 8'h1, 8'(ctrl_oe));
        chk("bus contention", 8'h0, 8'(drives_lines & ctrl_oe));
    endtask

    task automatic t_local_ready;
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            mc_rdy_n <= i[0];
            @(posedge clk);
            @(negedge clk);
            chk("local ready", 8'(i[0]), 8'(lro_n));
        end
    endtask

    task automatic t_float;
        do_reset(1'b1, 1'b0, 1'b1, 1'b0);
        chk("float", 8'h1, 8'(float_mode));
        chk("clock stop", 8'h1, 8'(clock_stop));
        chk("bus test", 8'h0, 8'(bus_conf));
        chk("oe", 8'h0, {5'h0, ctrl_oe, grant_oe, lro_oe});
        @(posedge clk);
        req <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0};
        repeat (3)
        begin
            @(negedge clk);
            chk("taken in float", 8'h0, 8'(req_taken));
        end
    endtask

    initial
    begin
        fail_count = 0;
        samples_checked = 0;
        srst = 1'b1;
        req = '0;
        {ch, fl_n, st, rt} = 4'hf;
        {mc_rdy_n, core_clr, retry_clr, want_bus} = 4'h8;
        wait_cycles = 4'h0;
        rcv_cycles = 4'h0;
        t_straps_held();
        t_straps_run();
        t_access_kinds();
        t_lock_hold();
        t_local_ready();
        t_float();
        report_and_stop();
    end
endmodule
